// ### hdl/strap_capture_defines.svh
// Purpose: offsets, field positions, reset values and counts for the strap/halt block
// Assumes: 32-bit classic wishbone register port, word aligned
// Notes:   included by the package and design files by bare name
`ifndef STRAP_CAPTURE_DEFINES_SVH
`define STRAP_CAPTURE_DEFINES_SVH

// register byte offsets
`define REG_STRAP_OFS      8'h00
`define REG_HALT_CTRL_OFS  8'h04
`define REG_HALT_STAT_OFS  8'h08
`define REG_ID_OFS         8'h0C

// captured option field positions in the strap word
`define FLD_TRISTATE       0
`define FLD_BIST           1
`define FLD_QUEUE_DEPTH    2
`define FLD_MC_OBS_OFF     3
`define FLD_BUS_REINIT_N_OBS_OFF  4
`define FLD_CLUSTER_LO     5
`define FLD_CLUSTER_HI     6
`define FLD_PARK_OFF       7
`define FLD_SMT_OFF        8
`define FLD_ARB_ID         9
`define STRAP_W            10

// halt control bits
`define CTL_HALT_REQ       0
`define CTL_SMM_RET_HALT   1
`define CTL_SMM_RETURN     2

// reset values
`define STRAP_RST          10'h000
`define QUEUE_DEPTH_FULL   4'h8
`define QUEUE_DEPTH_ONE    4'h1
`define ID_VALUE           32'h0000_5A01

`endif

// ### hdl/strap_capture_pkg.sv
// Purpose: shared types for the strap capture and halt power-down block
// Assumes: constants come from strap_capture_defines.svh
// Notes:   types only
`include "strap_capture_defines.svh"
package strap_capture_pkg;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_HALT,
        ST_HALT_STOPCLK
    } pwr_state_t;

    typedef struct packed {
        logic       smt_off;
        logic       park_off;
        logic [1:0] cluster_id;
        logic       bus_reinit_n_obs_off;
        logic       mc_obs_off;
        logic       queue_depth;
        logic       bist;
        logic       tristate;
        logic       arb_id;
    } strap_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// ### hdl/strap_latch.sv
// Purpose: capture-once register for one option group at reset release
// Assumes: arm_i is high for exactly one cycle after reset release
// Notes:   async reset loads a constant; pins captured by the clock only
`timescale 1ns/1ps
module strap_latch
#(
    parameter int W = 1
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic         arm_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] q_o
);

    // load only on the armed cycle, then hold until the next reset
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            q_o <= '0;
        else if (ce_i && arm_i)
            q_o <= pin_i;
    end

endmodule

// ### hdl/strap_capture_and_halt_powerdown_state.sv
// Purpose: power-on option capture and halt power-down state control
// Assumes: straps stable around reset release; wishbone classic slave
// Notes:   one reset path for power-up and in-operation resets
`timescale 1ns/1ps
`include "strap_capture_defines.svh"
module strap_capture_and_halt_powerdown_state
    import strap_capture_pkg::*;
#(
    parameter int QDEPTH_W = 4
)
(
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                ce_i,
    // wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     wb_err_o,
    // strap pins, active low, sampled at reset release
    input  wire logic                sys_mgmt_irq_n_i,
    input  wire logic                soft_init_n_i,
    input  wire logic                strap_queue_depth_n_i,
    input  wire logic                strap_mc_obs_off_n_i,
    input  wire logic                strap_bus_reinit_n_obs_off_n_i,
    input  wire logic [1:0]          strap_cluster_n_i,
    input  wire logic                strap_park_off_n_i,
    input  wire logic                strap_smt_off_n_i,
    input  wire logic                bus_request0_n_i,
    // run-time events
    input  wire logic                bus_reinit_n_i,
    input  wire logic [1:0]          local_irq_lines_i,
    input  wire logic                clock_stop_req_n_i,
    input  wire logic                halt_exec_i,
    input  wire logic                snoop_req_i,
    input  wire logic                irq_msg_i,
    // captured options, queue depth, power state and acknowledges to the core
    output strap_t                   options_o,
    output logic      [QDEPTH_W-1:0] in_order_queue_depth_o,
    output logic                     halted_o,
    output logic                     stop_clk_o,
    output logic                     init_busy_o,
    output logic                     wake_o,
    output logic                     snoop_ack_o,
    output logic                     irq_taken_o
);

    // capture arm: first enabled cycle after reset release
    logic       armed;
    logic       arm;
    strap_t     cap;
    logic [9:0] cap_bits;

    // strap pins are active low: asserted (low) selects the option
    wire logic [9:0] strap_pins = {
        ~strap_smt_off_n_i,
        ~strap_park_off_n_i,
        ~strap_cluster_n_i,
        ~strap_bus_reinit_n_obs_off_n_i,
        ~strap_mc_obs_off_n_i,
        ~strap_queue_depth_n_i,
        ~soft_init_n_i,
        ~sys_mgmt_irq_n_i,
        ~bus_request0_n_i
    };

    assign arm = ce_i && !armed;

    // the only path back to unarmed is reset, so every reset is identical
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            armed <= 1'b0;
        else if (ce_i)
            armed <= 1'b1;
    end

    // one shared capture register; kept as its own module for reuse
    strap_latch #(.W(10)) u_latch
    (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .arm_i   (arm),
        .pin_i   (strap_pins),
        .q_o     (cap_bits)
    );

    assign cap = strap_t'(cap_bits);
    assign options_o = cap;

    // queue depth limited to one when the pipelining strap was asserted
    wire logic [QDEPTH_W-1:0] next_depth = cap.queue_depth ?
        QDEPTH_W'(`QUEUE_DEPTH_ONE) : QDEPTH_W'(`QUEUE_DEPTH_FULL);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            in_order_queue_depth_o <= QDEPTH_W'(`QUEUE_DEPTH_FULL);
        else if (ce_i)
            in_order_queue_depth_o <= next_depth;
    end

    // cluster id is a straight field of the capture word, 0 to 3
    wire logic [1:0] cluster_id = cap.cluster_id;

    // init busy for the cycle of capture: reset starts init at once
    assign init_busy_o = !armed;

    // power state machine
    pwr_state_t state;
    pwr_state_t next_state;
    logic       smm_ret_halt;
    logic       smm_return;
    logic       halt_req_sw;

    // wake events; snoops and interrupt messages do not leave halt
    wire logic wake_evt = !sys_mgmt_irq_n_i || !bus_reinit_n_i
                        || !soft_init_n_i || (|local_irq_lines_i);
    wire logic halt_cmd = halt_exec_i || halt_req_sw;
    wire logic stop_req = !clock_stop_req_n_i;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_NORMAL:
                if (smm_return && smm_ret_halt)
                    next_state = ST_HALT;
                else if (halt_cmd && !wake_evt)
                    next_state = ST_HALT;
            ST_HALT:
                if (wake_evt)
                    next_state = ST_NORMAL;
                else if (stop_req)
                    next_state = ST_HALT_STOPCLK;
            ST_HALT_STOPCLK:
                if (!stop_req)
                    next_state = ST_HALT;
            default:
                next_state = ST_NORMAL;
        endcase
    end

    // async reset abandons any state immediately
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state <= ST_NORMAL;
        else if (ce_i)
            state <= next_state;
    end

    assign halted_o   = (state != ST_NORMAL);
    assign stop_clk_o = (state == ST_HALT_STOPCLK);
    assign wake_o     = (state == ST_HALT) && wake_evt;

    // snoops and interrupt messages are answered in every state
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            snoop_ack_o <= 1'b0;
            irq_taken_o <= 1'b0;
        end
        else if (ce_i)
        begin
            snoop_ack_o <= snoop_req_i;
            irq_taken_o <= irq_msg_i;
        end
    end

    // wishbone decode
    wire logic req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic hit_strap = (wb_adr_i == `REG_STRAP_OFS);
    wire logic hit_ctrl  = (wb_adr_i == `REG_HALT_CTRL_OFS);
    wire logic hit_stat  = (wb_adr_i == `REG_HALT_STAT_OFS);
    wire logic hit_id    = (wb_adr_i == `REG_ID_OFS);
    wire logic hit_any   = hit_strap || hit_ctrl || hit_stat || hit_id;
    wire logic ctrl_wr   = req && hit_any && hit_ctrl && wb_we_i && wb_sel_i[0];

    // strap word is read only: software cannot alter captured options
    wire logic [31:0] strap_word = {22'h00_0000, cap.arb_id, cap.smt_off, cap.park_off,
                                    cluster_id, cap.bus_reinit_n_obs_off, cap.mc_obs_off,
                                    cap.queue_depth, cap.bist, cap.tristate};
    wire logic [31:0] ctrl_word = {29'h0000_0000, 1'b0, smm_ret_halt, 1'b0};
    wire logic [31:0] stat_word = {28'h000_0000, in_order_queue_depth_o[0], stop_clk_o,
                                   halted_o, armed};
    wire logic [31:0] rd_mux = hit_strap ? strap_word :
                               hit_ctrl  ? ctrl_word  :
                               hit_stat  ? stat_word  :
                               hit_id    ? `ID_VALUE  : 32'h0000_0000;

    // halt request and smm return are self-clearing pulses
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            halt_req_sw  <= 1'b0;
            smm_return   <= 1'b0;
            smm_ret_halt <= 1'b0;
        end
        else if (ce_i)
        begin
            halt_req_sw <= ctrl_wr && wb_dat_i[`CTL_HALT_REQ];
            smm_return  <= ctrl_wr && wb_dat_i[`CTL_SMM_RETURN];
            if (ctrl_wr)
                smm_ret_halt <= wb_dat_i[`CTL_SMM_RET_HALT];
        end
    end

    // one-cycle answer; err for unmapped addresses
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= req && hit_any;
            wb_err_o <= req && !hit_any;
            wb_dat_o <= rd_mux;
        end
    end

endmodule

// ### sim/strap_capture_and_halt_powerdown_state_chk.sv
// Purpose: port-level checks of option capture and halt power-down
// Assumes: one clock domain, reset disables every check
// Notes:   bound to the top module; names match its ports
`timescale 1ns/1ps
module strap_capture_and_halt_powerdown_state_chk
    import strap_capture_pkg::*;
#(
    parameter int QDEPTH_W = 4
)
(
    input wire logic                clk_i,
    input wire logic                rst_b_i,
    input wire logic                ce_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_ack_o,
    input wire logic                wb_err_o,
    input wire logic                sys_mgmt_irq_n_i,
    input wire logic                soft_init_n_i,
    input wire logic                bus_reinit_n_i,
    input wire logic [1:0]          local_irq_lines_i,
    input wire logic                clock_stop_req_n_i,
    input wire logic                halt_exec_i,
    input wire logic                snoop_req_i,
    input wire logic                irq_msg_i,
    input wire strap_t              options_o,
    input wire logic [QDEPTH_W-1:0] in_order_queue_depth_o,
    input wire logic                halted_o,
    input wire logic                stop_clk_o,
    input wire logic                init_busy_o,
    input wire logic                wake_o,
    input wire logic                snoop_ack_o,
    input wire logic                irq_taken_o
);
    // any wake source, pins are active low except the local lines
    wire logic wk = !sys_mgmt_irq_n_i | !soft_init_n_i | !bus_reinit_n_i
                  | (|local_irq_lines_i);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // two settled cycles past init, so the capture edge itself is excused
    chk_opts_hold: assert property (
        !init_busy_o && $past(!init_busy_o, 2) |-> $stable(options_o))
        else $error("options moved after capture");
    chk_depth_map: assert property (!init_busy_o && $past(!init_busy_o, 2) |->
        in_order_queue_depth_o == (options_o.queue_depth ? 4'h1 : 4'h8))
        else $error("queue depth does not follow its option");
    chk_halt_enter: assert property (
        ce_i && !init_busy_o && halt_exec_i && !halted_o && !wk |=> halted_o)
        else $error("halt instruction did not halt");
    chk_wake_exit: assert property (
        ce_i && halted_o && !stop_clk_o && wk && clock_stop_req_n_i |=> !halted_o)
        else $error("wake event left the block halted");
    chk_wake_flag: assert property (halted_o && !stop_clk_o |-> wake_o == wk)
        else $error("wake flag wrong while halted");
    chk_stop_enter: assert property (
        ce_i && halted_o && !stop_clk_o && !wk && !clock_stop_req_n_i
        |=> stop_clk_o && halted_o)
        else $error("stop request not taken while halted");
    chk_stop_leave: assert property (
        ce_i && stop_clk_o && clock_stop_req_n_i |=> halted_o && !stop_clk_o)
        else $error("stop release did not return to halt");
    chk_halt_snoop: assert property (
        ce_i && halted_o && snoop_req_i && irq_msg_i |=> snoop_ack_o && irq_taken_o)
        else $error("snoop or interrupt ignored while halted");
    chk_bus_answer: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o)
        else $error("bus cycle not answered by exactly one of ack and err");
    cov_halt: cover property (halt_exec_i ##1 halted_o);
    cov_stop: cover property (stop_clk_o ##1 !stop_clk_o && halted_o);
    cov_err: cover property (wb_err_o);
endmodule
bind strap_capture_and_halt_powerdown_state strap_capture_and_halt_powerdown_state_chk #(.QDEPTH_W(QDEPTH_W)) u_chk (.*);

// ### sim/sys_logic_model.sv
// Purpose: system logic driving the strap pins around reset release
// Assumes: pick_i is settled before reset is released
// Notes:   pins swing to inverted levels after capture, so a re-capture shows
`timescale 1ns/1ps
module sys_logic_model
    import strap_capture_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    input  wire strap_t pick_i,
    input  wire logic   smi_n_i,
    input  wire logic   init_n_i,
    output strap_t      pins_n_o
);
    logic [2:0] hold;
    wire logic  held = (hold == 3'h4);
    // a few cycles of stable levels past release
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hold <= 3'h0;
        else if (!held)
            hold <= hold + 3'h1;
    end
    // selected options low through release; smi and init then become wake events
    always_comb
    begin
        pins_n_o = held ? pick_i : ~pick_i;
        if (held)
        begin
            pins_n_o.tristate = smi_n_i;
            pins_n_o.bist     = init_n_i;
        end
    end
endmodule

// ### sim/strap_capture_and_halt_powerdown_state_tb_top.sv
// Purpose: self-checking bench for option capture and halt power-down
// Assumes: clock enable held high, all bytes selected
// Notes:   patterns set every option both ways and every cluster id
`timescale 1ns/1ps
`include "strap_capture_defines.svh"
module strap_capture_and_halt_powerdown_state_tb_top
    import strap_capture_pkg::*;
;
    logic clk_i = 1'b0, rst_b_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic wb_ack_o, wb_err_o, halt_exec_i = 1'b0, clock_stop_req_n_i = 1'b1;
    logic snoop_req_i = 1'b0, irq_msg_i = 1'b0;
    logic halted_o, stop_clk_o, init_busy_o, wake_o, snoop_ack_o, irq_taken_o;
    logic [3:0] in_order_queue_depth_o;
    logic [4:0] wk = 5'h00; // wake sources: smi, init, reinit, lint0, lint1
    logic [9:0] pat [4] = '{10'h000, 10'h155, 10'h2AA, 10'h3FF};
    strap_t options_o, pick = '0, pins_n;
    int err_count = 0, n_checks = 0;
    // strap and wake pins as the system board routes them
    wire logic sys_mgmt_irq_n_i = pins_n.tristate;
    wire logic soft_init_n_i = pins_n.bist;
    wire logic strap_queue_depth_n_i = pins_n.queue_depth;
    wire logic strap_mc_obs_off_n_i = pins_n.mc_obs_off;
    wire logic strap_bus_reinit_n_obs_off_n_i = pins_n.bus_reinit_n_obs_off;
    wire logic [1:0] strap_cluster_n_i = pins_n.cluster_id;
    wire logic strap_park_off_n_i = pins_n.park_off;
    wire logic strap_smt_off_n_i = pins_n.smt_off;
    wire logic bus_request0_n_i = pins_n.arb_id;
    wire logic bus_reinit_n_i = !wk[2];
    wire logic [1:0] local_irq_lines_i = wk[4:3];
    always #4 clk_i = ~clk_i;
    sys_logic_model sys (.clk_i(clk_i), .rst_b_i(rst_b_i), .pick_i(pick),
        .smi_n_i(!wk[0]), .init_n_i(!wk[1]), .pins_n_o(pins_n));
    strap_capture_and_halt_powerdown_state dut (.ce_i(1'b1), .wb_sel_i(4'hF), .*);
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle; held until ack or err, bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && ++n < 20);
        cmp({wb_ack_o, wb_err_o}, {!er, er});
        if (!w)
            cmp(wb_dat_o, e);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // reset with pattern p on the straps, then look at what stuck
    task automatic boot(input strap_t p);
        pick <= p;
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        cmp({init_busy_o, in_order_queue_depth_o}, 5'h18);
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
        cmp(options_o, p);
        cmp(in_order_queue_depth_o, p.queue_depth ? 32'h1 : 32'h8);
    endtask
    task automatic enter();
        @(posedge clk_i);
        halt_exec_i <= 1'b1;
        @(posedge clk_i);
        halt_exec_i <= 1'b0;
        #1;
        cmp(halted_o, 1'b1);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        foreach (pat[i])
            boot(pat[i]);
        $display("capture test done");
        enter();
        {snoop_req_i, irq_msg_i} <= 2'b11;
        @(posedge clk_i);
        {snoop_req_i, irq_msg_i} <= 2'b00;
        #1;
        cmp({snoop_ack_o, irq_taken_o, halted_o}, 3'h7);
        clock_stop_req_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp({halted_o, stop_clk_o}, 2'h3);
        clock_stop_req_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        cmp({halted_o, stop_clk_o}, 2'h2);
        // every wake source in turn, halting again after each
        for (int i = 0; i < 5; i++)
        begin
            wk <= 5'h01 << i;
            #1;
            cmp(wake_o, 1'b1);
            @(posedge clk_i);
            wk <= 5'h00;
            #1;
            cmp(halted_o, 1'b0);
            enter();
        end
        rst_b_i <= 1'b0;
        #1;
        cmp({init_busy_o, halted_o}, 2'h2);
        boot(pat[1]);
        $display("halt test done");
        wb(1'b1, 8'h04, 32'h0000_0006, 32'h0, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        cmp(halted_o, 1'b1);
        wk <= 5'h01;
        @(posedge clk_i);
        wk <= 5'h00;
        wb(1'b0, 8'h04, 32'h0, 32'h0000_0002, 1'b0);
        wb(1'b1, 8'h04, 32'h0000_0004, 32'h0, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        cmp(halted_o, 1'b0);
        wb(1'b1, 8'h04, 32'h0000_0001, 32'h0, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        cmp(halted_o, 1'b1);
        wk <= 5'h01;
        @(posedge clk_i);
        wk <= 5'h00;
        // strap word in field order; pattern 0x155 packs to 0x2AA here
        wb(1'b0, 8'h00, 32'h0, 32'h0000_02AA, 1'b0);
        wb(1'b0, 8'h08, 32'h0, 32'h0000_0001, 1'b0);
        wb(1'b0, 8'h0C, 32'h0, `ID_VALUE, 1'b0);
        wb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        $display("register test done");
        wrap_up();
    end
endmodule
